// *** logic/twb_regs.svh ***
// Bit positions, bit counts, address codes and timing figures of the two-wire framing block
`ifndef TWB_REGS_SVH
`define TWB_REGS_SVH

// Bit index within a nine-bit packet
`define TWB_BIT_LAST   4'h8
`define TWB_ADDR_LAST  4'h7
// Reserved slave address codes
`define TWB_GC_ADDR    7'h00
`define TWB_RSVD_TOP   4'hf
// Fixed part of one bit period, in system clocks
`define TWB_BASE_CYC   16'h0010
`define TWB_BASE_HALF  16'h0008
// Reset value of every piece of core state
`define TWB_CORE_RST   '0

`endif

// *** logic/twb_pkg.sv ***
// Types shared by the two-wire bus framing block
package twb_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_LOW    = 3'b010,
    ST_HIGH   = 3'b011,
    ST_HOLD   = 3'b100,
    ST_SLAVE  = 3'b101,
    ST_RSTART = 3'b110,
    ST_STOP   = 3'b111
  } state_t;

  // Reason the event flag was raised
  typedef enum logic [2:0] {
    EV_NONE       = 3'b000,
    EV_START      = 3'b001,
    EV_ADDR       = 3'b010,
    EV_DATA       = 3'b011,
    EV_SLAVE_ADDR = 3'b100,
    EV_ARB_LOST   = 3'b101
  } event_t;

  // Command given together with clearing the event flag
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       ack;
    logic [7:0] data;
  } cmd_t;

  // Static configuration
  typedef struct packed {
    logic [6:0] ownAddr;
    logic       genCallEn;
    logic       ackEn;
    logic [7:0] bitRateDivisor;
    logic [1:0] prescale;
  } cfg_t;

  // Status seen by software
  typedef struct packed {
    logic master;
    logic txMode;
    logic addressed;
    logic genCall;
    logic ackSeen;
    logic arbLost;
    logic busBusy;
  } status_t;

  // Whole state of the framing core
  typedef struct packed {
    state_t     state;
    logic       phase;
    logic [15:0] cnt;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] rxByte;
    logic       master;
    logic       txMode;
    logic       addrPhase;
    logic       dirRead;
    logic       addressed;
    logic       genCall;
    logic       ackOut;
    logic       ackSeen;
    logic       addrNack;
    logic       arbLost;
    logic       pendStart;
    logic       busBusy;
    logic       sclOe;
    logic       sdaOe;
    logic       eventFlag;
    event_t     eventKind;
    logic       sclMeta;
    logic       sclS;
    logic       sclP;
    logic       sdaMeta;
    logic       sdaS;
    logic       sdaP;
  } core_t;

endpackage

// *** logic/two_wire_bus_framing.sv ***
// Two-wire bus framing core: master and slave bit, byte and condition sequencing
`timescale 1ns/1ps
`include "twb_regs.svh"

module two_wire_bus_framing
  import twb_pkg::*;
(
  // Clock and reset
  input  wire logic    clock,
  input  wire logic    nrst,
  // Bus pins, open drain
  input  wire logic    sclIn,
  output logic         sclOut,
  output logic         sclOe,
  input  wire logic    sdaIn,
  output logic         sdaOut,
  output logic         sdaOe,
  // Configuration
  input  wire logic    busPowerReduceBit,
  input  wire cfg_t    cfg,
  // Command, taken with the clearing of the event flag
  input  wire logic    cmdValid,
  input  wire cmd_t    cmd,
  // Event and status
  output logic         busEventFlag,
  output event_t       eventKind,
  output logic [7:0]   rxByte,
  output status_t      status
);

  core_t q;
  core_t n;

  logic [6:0]  preVal;
  logic [14:0] prod;
  logic [15:0] halfCyc;
  logic [15:0] halfLast;
  logic        startSeen;
  logic        stopSeen;
  logic        sampleNow;
  logic        endNow;
  logic        pullScl;
  logic        dataLow;
  logic        allowSda;
  logic        ownMatch;
  logic        gcMatch;

  // Half bit period: (16 + 2*divisor*4^prescale) / 2 system clocks
  assign preVal   = 7'h01 << {cfg.prescale, 1'b0};
  assign prod     = 15'(cfg.bitRateDivisor) * 15'(preVal);
  assign halfCyc  = `TWB_BASE_HALF + {1'b0, prod};
  assign halfLast = halfCyc - 16'h0001;

  // Bus conditions from synchronised lines only
  assign startSeen = q.sclS && q.sclP && q.sdaP && !q.sdaS;
  assign stopSeen  = q.sclS && q.sclP && !q.sdaP && q.sdaS;

  // Sample on first high cycle; end bit at high-phase end or on clock fall
  assign sampleNow = (q.state == ST_HIGH && q.sclS && q.cnt == 16'h0000)
                  || (q.state == ST_SLAVE && q.sclS && !q.sclP && !q.phase);
  assign endNow    = (q.state == ST_HIGH && q.sclS && q.cnt == halfLast)
                  || (q.state == ST_SLAVE && !q.sclS && q.sclP && q.phase);

  // Address recognition; zero and 1111xxx never count as own address
  assign ownMatch = q.shiftReg[6:0] == cfg.ownAddr && cfg.ownAddr != `TWB_GC_ADDR
                 && cfg.ownAddr[6:3] != `TWB_RSVD_TOP;
  // General call answered only with write direction
  assign gcMatch  = q.shiftReg[6:0] == `TWB_GC_ADDR && cfg.genCallEn && !q.sdaS;

  // Next state of the whole core
  always_comb begin
    n = q;
    n.sclMeta = sclIn;
    n.sclS    = q.sclMeta;
    n.sclP    = q.sclS;
    n.sdaMeta = sdaIn;
    n.sdaS    = q.sdaMeta;
    n.sdaP    = q.sdaS;

    case (q.state)
      ST_IDLE: begin
        if (cmdValid && cmd.start) begin
          n.pendStart = 1'b1;
        end
        // Never seize a busy bus
        if (q.pendStart && !q.busBusy) begin
          n.state     = ST_START;
          n.phase     = 1'b0;
          n.cnt       = 16'h0000;
          n.pendStart = 1'b0;
        end
      end
      ST_START: begin
        if (!q.phase) begin
          // Both lines must be seen high for a half period first
          if (q.sclS && q.sdaS) begin
            n.cnt = q.cnt + 16'h0001;
            if (q.cnt == halfLast) begin
              n.phase = 1'b1;
              n.cnt   = 16'h0000;
            end
          end else begin
            n.cnt = 16'h0000;
          end
        end else begin
          n.cnt = q.cnt + 16'h0001;
          if (q.cnt == halfLast) begin
            n.state     = ST_HOLD;
            n.master    = 1'b1;
            n.txMode    = 1'b1;
            n.addrPhase = 1'b1;
            n.bitCnt    = 4'h0;
            n.arbLost   = 1'b0;
            n.addressed = 1'b0;
            n.addrNack  = 1'b0;
            n.eventFlag = 1'b1;
            n.eventKind = EV_START;
          end
        end
      end
      ST_RSTART, ST_LOW: begin
        n.cnt = q.cnt + 16'h0001;
        if (q.cnt == halfLast) begin
          n.state = (q.state == ST_LOW) ? ST_HIGH : ST_START;
          n.phase = 1'b0;
          n.cnt   = 16'h0000;
        end
      end
      ST_HIGH: begin
        // High time counts only once the line is really high
        if (q.sclS) begin
          n.cnt = q.cnt + 16'h0001;
        end
      end
      ST_HOLD: begin
        if (cmdValid) begin
          n.eventFlag = 1'b0;
          if (q.master) begin
            if (cmd.start) begin
              n.state = ST_RSTART;
              n.cnt   = 16'h0000;
            end else if ((cmd.stop && !q.addrPhase) || q.addrNack) begin
              n.state = ST_STOP;
              n.phase = 1'b0;
              n.cnt   = 16'h0000;
            end else begin
              n.state    = ST_LOW;
              n.cnt      = 16'h0000;
              n.shiftReg = q.txMode ? cmd.data : q.shiftReg;
              n.ackOut   = cmd.ack;
              if (q.addrPhase) begin
                n.dirRead = cmd.data[0];
              end
            end
          end else if (q.addressed) begin
            n.state    = ST_SLAVE;
            n.phase    = 1'b0;
            n.shiftReg = q.txMode ? cmd.data : q.shiftReg;
            n.ackOut   = cmd.ack;
          end else begin
            n.state   = ST_IDLE;
            n.arbLost = 1'b0;
          end
        end
      end
      ST_STOP: begin
        if (!q.phase) begin
          n.cnt = q.cnt + 16'h0001;
          if (q.cnt == halfLast) begin
            n.phase = 1'b1;
            n.cnt   = 16'h0000;
          end
        end else if (q.sclS) begin
          n.cnt = q.cnt + 16'h0001;
          if (q.cnt == halfLast) begin
            n.state  = ST_IDLE;
            n.master = 1'b0;
          end
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // Bit sample on the rising side of the clock
    if (sampleNow) begin
      n.phase = 1'b1;
      if (q.bitCnt != `TWB_BIT_LAST) begin
        n.shiftReg = {q.shiftReg[6:0], q.sdaS};
        // Released high but read low: another master wins
        if (q.master && q.txMode && q.shiftReg[7] && !q.sdaS) begin
          n.arbLost = 1'b1;
          n.master  = 1'b0;
          n.txMode  = 1'b0;
          n.state   = ST_SLAVE;
        end
        if (q.addrPhase && q.bitCnt == `TWB_ADDR_LAST) begin
          n.dirRead = q.sdaS;
          if (!n.master) begin
            n.addressed = (gcMatch || ownMatch) && cfg.ackEn;
            n.genCall   = gcMatch && cfg.ackEn;
            n.ackOut    = 1'b1;
          end
        end
      end else begin
        if (q.txMode) begin
          n.ackSeen = !q.sdaS;
        end
        if (q.addrPhase && q.master) begin
          n.addrNack = q.sdaS;
        end
      end
    end

    // End of a bit on the falling side of the clock
    if (endNow) begin
      n.phase = 1'b0;
      n.cnt   = 16'h0000;
      if (q.bitCnt == `TWB_BIT_LAST) begin
        n.bitCnt    = 4'h0;
        n.rxByte    = q.shiftReg;
        n.addrPhase = 1'b0;
        n.eventFlag = 1'b1;
        n.state     = ST_HOLD;
        if (q.master) begin
          n.eventKind = q.addrPhase ? EV_ADDR : EV_DATA;
          if (q.addrPhase) begin
            n.txMode = !q.dirRead;
          end
        end else if (q.addressed) begin
          n.eventKind = q.addrPhase ? EV_SLAVE_ADDR : EV_DATA;
          if (q.addrPhase) begin
            n.txMode = q.dirRead;
          end
          // A refused byte ends a slave transmission
          if (q.txMode && !q.ackSeen) begin
            n.addressed = 1'b0;
          end
        end else if (q.arbLost) begin
          n.eventKind = EV_ARB_LOST;
        end else begin
          n.eventFlag = 1'b0;
          n.state     = ST_IDLE;
        end
      end else begin
        n.bitCnt = q.bitCnt + 4'h1;
        if (q.master) begin
          n.state = ST_LOW;
        end
      end
    end

    // Conditions made by any master on the bus
    if (startSeen) begin
      n.busBusy = 1'b1;
      if (!q.master && !(q.state == ST_START && q.phase)) begin
        n.pendStart = q.pendStart || q.state == ST_START;
        n.state     = ST_SLAVE;
        n.phase     = 1'b0;
        n.bitCnt    = 4'h0;
        n.addrPhase = 1'b1;
        n.addressed = 1'b0;
        n.genCall   = 1'b0;
        n.txMode    = 1'b0;
      end
    end
    if (stopSeen) begin
      n.busBusy = 1'b0;
      if (!q.master && q.state == ST_SLAVE) begin
        n.state     = ST_IDLE;
        n.addressed = 1'b0;
      end
    end

    // Clock line pulled only in the low phase, while holding, in repeated start and in the first half of stop
    case (n.state)
      ST_LOW, ST_HOLD, ST_RSTART: pullScl = 1'b1;
      ST_STOP:                    pullScl = !n.phase;
      default:                    pullScl = 1'b0;
    endcase
    n.sclOe = pullScl;

    // Data bit or acknowledge wanted on the data line
    if (n.bitCnt == `TWB_BIT_LAST) begin
      dataLow = !n.txMode && n.ackOut && (n.master || n.addressed);
    end else begin
      dataLow = n.txMode && (n.master || n.addressed) && !n.shiftReg[7];
    end
    // Outside start and stop conditions, data changes only once the clock line is surely low
    allowSda = (q.sclOe && pullScl) || (!q.master && !q.sclS && !q.sclP);
    case (n.state)
      ST_IDLE, ST_RSTART: n.sdaOe = 1'b0;
      ST_START:           n.sdaOe = n.phase;
      ST_STOP:            n.sdaOe = 1'b1;
      default: begin
        if (allowSda) begin
          n.sdaOe = dataLow;
        end
      end
    endcase

    // Power reduction holds everything at its reset value
    if (!busPowerReduceBit) begin
      n = n;
    end else begin
      n = `TWB_CORE_RST;
    end
  end

  // Single state register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      q <= `TWB_CORE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register; pins only ever pull low
  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign sclOe        = q.sclOe;
  assign sdaOe        = q.sdaOe;
  assign busEventFlag = q.eventFlag;
  assign eventKind    = q.eventKind;
  assign rxByte       = q.rxByte;
  assign status       = '{q.master, q.txMode, q.addressed, q.genCall,
                          q.ackSeen, q.arbLost, q.busBusy};

  // Stop begun with clock and data low; repeated start begun with bus still busy and data released
  sequence sStopLow;
    q.state == ST_STOP && !q.phase && q.sclOe && q.sdaOe;
  endsequence
  sequence sRepStart;
    q.state == ST_RSTART && q.busBusy && !q.sdaOe;
  endsequence

  a_flag_holds_clock: assert property (@(posedge clock) disable iff (!nrst)
    q.eventFlag |-> q.sclOe)
    else $error("event flag set while clock line released");
  a_power_idle: assert property (@(posedge clock) disable iff (!nrst)
    busPowerReduceBit |=> q.state == ST_IDLE && !q.sclOe && !q.sdaOe)
    else $error("block active while power reduced");
  a_data_steady: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_HIGH && $past(q.state) == ST_HIGH) |-> $stable(q.sdaOe))
    else $error("data line changed during clock high");
  a_low_length: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_LOW && q.cnt == halfLast) |=> q.state == ST_HIGH && !q.sclOe)
    else $error("low phase length wrong");
  a_stretch_wait: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_HIGH && !q.sclS) |=> q.state == ST_HIGH && $stable(q.cnt))
    else $error("master advanced while clock line held low");
  a_msb_first: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_LOW && q.cnt != 16'h0000 && q.master && q.txMode
     && q.bitCnt != `TWB_BIT_LAST) |-> q.sdaOe == !q.shiftReg[7])
    else $error("transmitted bit is not the top bit");
  a_ack_drive: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_LOW && q.cnt != 16'h0000 && q.master && !q.txMode
     && q.bitCnt == `TWB_BIT_LAST) |-> q.sdaOe == q.ackOut)
    else $error("master receiver acknowledge wrong");
  a_gc_write_only: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.genCall && q.addressed) |-> !q.dirRead)
    else $error("general call accepted with read direction");
  a_busy_start: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    startSeen |=> q.busBusy)
    else $error("bus not busy after start");
  a_addr_nack_stop: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_HOLD && cmdValid && q.master && q.addrNack && !cmd.start)
      |=> sStopLow)
    else $error("refused address not ended by stop");
  a_rep_start: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (q.state == ST_HOLD && cmdValid && q.master && cmd.start) |=> sRepStart)
    else $error("repeated start not begun with bus held");
  a_arb_release: assert property (@(posedge clock)
    disable iff (!nrst || busPowerReduceBit)
    (sampleNow && q.master && q.txMode && q.shiftReg[7] && !q.sdaS
     && q.bitCnt != `TWB_BIT_LAST && !startSeen && !stopSeen)
      |=> (!q.master && q.arbLost && !q.sdaOe) ##1 !q.sdaOe)
    else $error("lost master kept driving data");

endmodule // two_wire_bus_framing

// *** sim/bus_slave_model.sv ***
// Behavioural slave device on the two-wire bus, with optional clock stretching
`timescale 1ns/1ps

module bus_slave_model #(
  parameter logic [6:0] SlaveAddr = 7'h2a  // Neither zero nor 1111xxx
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Pull-downs, high pulls the line low, never drives high
  output logic            sclPull,
  output logic            sdaPull,
  // Behaviour knobs and observations
  input  wire logic [7:0] readByte,
  input  wire logic [7:0] stretch,
  output logic [7:0]      lastByte,
  output logic            gotStop,
  output logic            mAck
);
  logic       sclP, sdaP, matched, rd, addrPh;
  logic [3:0] bitCnt;
  logic [7:0] sh, txSh, sCnt;

  // Line watcher; changes data only after a clock fall, so data is steady while high
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {sclP, sdaP} <= 2'h3;
      {sclPull, sdaPull, matched, rd, addrPh, mAck, gotStop} <= '0;
      {bitCnt, sh, txSh, sCnt, lastByte} <= '0;
    end else begin
      sclP <= scl;
      sdaP <= sda;
      // Stretch countdown; a new fall below restarts it
      if (sCnt != 8'h00) begin
        sCnt <= sCnt - 8'h01;
        sclPull <= (sCnt != 8'h01);
      end
      if (scl && sclP && sdaP && !sda) begin  // Start seen
        {bitCnt, matched, sdaPull, gotStop} <= '0;
        addrPh <= 1'b1;
      end else if (scl && sclP && !sdaP && sda) begin  // Stop seen
        gotStop <= 1'b1;
        sdaPull <= 1'b0;
      end else if (scl && !sclP) begin
        if (bitCnt < 4'h8) sh <= {sh[6:0], sda};  // MSB first
        else mAck <= !sda;  // Low ninth bit acknowledges
        bitCnt <= bitCnt + 4'h1;
      end else if (!scl && sclP) begin
        if (stretch != 8'h00) begin  // Lengthens low phase only
          sclPull <= 1'b1;
          sCnt <= stretch;
        end
        if (bitCnt == 4'h8) begin  // Receiver answers ninth pulse
          if (addrPh) begin
            matched <= (sh[7:1] == SlaveAddr);
            rd <= sh[0];  // One reads
            sdaPull <= (sh[7:1] == SlaveAddr);
          end else begin
            if (matched && !rd) lastByte <= sh;
            sdaPull <= matched && !rd;
          end
        end else if (bitCnt == 4'h9) begin
          // Withhold the first bit of the next byte once the master refuses
          bitCnt <= 4'h0;
          addrPh <= 1'b0;
          txSh <= {readByte[6:0], 1'b0};
          sdaPull <= matched && rd && (addrPh || mAck) && !readByte[7];
        end else if (matched && rd && !addrPh && bitCnt != 4'h0) begin
          sdaPull <= !txSh[7];
          txSh <= {txSh[6:0], 1'b0};
        end
      end
    end
  end
endmodule // bus_slave_model

// *** sim/two_wire_bus_framing_test.sv ***
// Self-checking bench: framing core as bus master against a slave model
`timescale 1ns/1ps

module two_wire_bus_framing_test;
  import twb_pkg::*;

  logic       clock, nrst, sclIn, sdaIn, sclOut, sdaOut, sclOe, sdaOe;
  logic       busPowerReduceBit, cmdValid, busEventFlag;
  logic       sclPull, sdaPull, gotStop, mAck;
  cfg_t       cfg;
  cmd_t       cmd;
  event_t     eventKind;
  status_t    status;
  logic [7:0] rxByte, readByte, stretch, lastByte;
  int         err_count, samples_checked, n, len;

  // Wired-AND with pull-ups: released lines read high
  assign sclIn = !(sclOe || sclPull);
  assign sdaIn = !(sdaOe || sdaPull);

  two_wire_bus_framing DUT (
    .clock(clock), .nrst(nrst), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .busPowerReduceBit(busPowerReduceBit),
    .cfg(cfg), .cmdValid(cmdValid), .cmd(cmd), .busEventFlag(busEventFlag),
    .eventKind(eventKind), .rxByte(rxByte), .status(status)
  );

  bus_slave_model slave (
    .clock(clock), .nrst(nrst), .scl(sclIn), .sda(sdaIn), .sclPull(sclPull),
    .sdaPull(sdaPull), .readByte(readByte), .stretch(stretch), .lastByte(lastByte),
    .gotStop(gotStop), .mAck(mAck)
  );

  // 10 MHz clock
  initial clock = 1'b0;
  always #50 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command, held for exactly one cycle
  task automatic send(input logic s, input logic p, input logic a, input logic [7:0] d);
    cmd = '{start: s, stop: p, ack: a, data: d};
    cmdValid = 1'b1;
    @(negedge clock);
    cmdValid = 1'b0;
  endtask

  // Bounded waits, so a stuck core shows as a mismatch rather than a hang
  task automatic wait_flag();
    n = 0;
    while (busEventFlag !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check(16'(n < 3000), 16'h0001);  // Event ends each step
  endtask

  task automatic wait_idle();
    n = 0;
    while (status.busBusy !== 1'b0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic wait_scl(input logic v);
    n = 0;
    while (sclOe !== v && n < 500) begin
      @(negedge clock);
      n++;
    end
    check(16'(n < 500), 16'h0001);  // Clock line keeps toggling
  endtask

  // Start, then address byte; never the general call with read
  task automatic open(input logic [7:0] a);
    send(1'b1, 1'b0, 1'b0, 8'h00);
    wait_flag();
    send(1'b0, 1'b0, 1'b0, a);
    wait_flag();
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #4_000_000;
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    busPowerReduceBit = 1'b0;
    readByte = 8'h3c;
    stretch = 8'h00;
    cfg = '{ownAddr: 7'h55, genCallEn: 1'b0, ackEn: 1'b0, bitRateDivisor: 8'h01,
            prescale: 2'h0};
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    check(16'({sclOe, sdaOe, busEventFlag, status}), 16'h0000);  // Idle after reset
    check(16'(rxByte), 16'h0000);  // Nothing received yet
    check(16'({sclOut, sdaOut}), 16'h0000);  // Lines only pulled low
    // Power-reduction holds the block idle even when asked to start
    busPowerReduceBit = 1'b1;
    send(1'b1, 1'b0, 1'b0, 8'h00);
    repeat (100) @(negedge clock);
    check(16'({sclOe, sdaOe, busEventFlag, status.busBusy}), 16'h0000);  // Idle
    busPowerReduceBit = 1'b0;
    repeat (5) @(negedge clock);
    // Write: stop right after start is refused and the byte goes out as address
    send(1'b1, 1'b0, 1'b0, 8'h00);
    wait_flag();
    check(16'(eventKind), 16'(EV_START));  // Start done
    check(16'(status.busBusy), 16'h0001);  // Busy
    repeat (30) @(negedge clock);
    check(16'({busEventFlag, sclOe}), 16'h0003);  // Clock held
    send(1'b0, 1'b1, 1'b0, 8'h54);
    wait_flag();
    check(16'(eventKind), 16'(EV_ADDR));  // Address sent
    check(16'(rxByte), 16'h0054);  // Address and direction
    check(16'(status.ackSeen), 16'h0001);  // Slave answered
    send(1'b0, 1'b0, 1'b0, 8'ha5);
    wait_scl(1'b0);
    wait_scl(1'b1);
    len = 0;
    while (sclOe === 1'b1 && len < 500) begin
      @(negedge clock);
      len++;
    end
    check(16'(len), 16'h0009);  // Low phase of 8 plus divisor
    wait_flag();
    check(16'(eventKind), 16'(EV_DATA));  // Data packet
    check(16'(lastByte), 16'h00a5);  // Byte MSB first
    check(16'(status.ackSeen), 16'h0001);  // Ack
    // Repeated start, then read two bytes: ack the first, refuse the last
    send(1'b1, 1'b0, 1'b0, 8'h00);
    wait_flag();
    check(16'({status.busBusy, eventKind}), 16'({1'b1, EV_START}));  // Still busy
    send(1'b0, 1'b0, 1'b0, 8'h55);
    wait_flag();
    check(16'({status.ackSeen, eventKind}), 16'({1'b1, EV_ADDR}));  // Read
    for (int i = 1; i >= 0; i--) begin
      send(1'b0, 1'b0, i[0], 8'h00);
      wait_flag();
      check(16'({rxByte, mAck}), 16'({8'h3c, i[0]}));  // Byte read; master acks the first, refuses the last
    end
    send(1'b0, 1'b1, 1'b0, 8'h00);
    wait_idle();
    check(16'({status.busBusy, gotStop}), 16'h0001);  // Freed by stop
    // Slave stretches every low phase
    stretch = 8'h1e;
    open(8'h54);
    send(1'b0, 1'b0, 1'b0, 8'h96);
    wait_flag();
    check(16'(lastByte), 16'h0096);  // Waits for clock release
    send(1'b0, 1'b1, 1'b0, 8'h00);
    wait_idle();
    stretch = 8'h00;
    // Unknown address is refused; a plain command then ends with stop
    open(8'h22);
    check(16'(status.ackSeen), 16'h0000);  // No slave
    send(1'b0, 1'b0, 1'b0, 8'h00);
    wait_idle();
    check(16'({status.busBusy, gotStop}), 16'h0001);  // Stop after refusal
    repeat (10) @(negedge clock);
    wrap_up();
  end
endmodule // two_wire_bus_framing_test
